// *** shared/odtpd_map.svh ***
/*
  Timing constants for the ODT power-down transition tracker.
  Assumes a 200 MHz core_clk that is also the memory clock reference.
*/
`ifndef ODTPD_MAP_SVH
`define ODTPD_MAP_SVH
`define ODTPD_CLK_PS          32'd5000
`define ODTPD_TAONPD_MIN_PS   32'd2000
`define ODTPD_TAONPD_MAX_PS   32'd8500
`define ODTPD_ASYNC_MIN_CYC   ((`ODTPD_TAONPD_MIN_PS + `ODTPD_CLK_PS - 32'd1) / `ODTPD_CLK_PS)
`define ODTPD_ASYNC_MAX_CYC   (((`ODTPD_TAONPD_MAX_PS / `ODTPD_CLK_PS) < 32'd1) ? 32'd1 : (`ODTPD_TAONPD_MAX_PS / `ODTPD_CLK_PS))
`define ODTPD_ODTL_OFS        8'h02
`define ODTPD_ANPD_OFS        8'h01
`endif

// *** shared/odtpd_pkg.sv ***
/*
  Types for the ODT power-down transition tracker.
  Assumes the map header supplies all numbers.
*/
package odtpd_pkg;
  typedef enum logic [1:0] {
    ODTPD_SYNC  = 2'b00,
    ODTPD_ENTRY = 2'b01,
    ODTPD_ASYNC = 2'b11,
    ODTPD_EXIT  = 2'b10
  } odtpd_mode_t;
endpackage : odtpd_pkg

// *** rtl/odtpd_transition.sv ***
/*
  Tracks ODT synchronous/asynchronous behaviour around precharge power-down
  entry and exit with the DLL off, and drives the resulting termination state.
  Assumes cke, odt, refresh_cmd come from the controller on core_clk, and that
  write latency and tRFC/tXPDLL counts are stable configuration inputs.
*/
`include "odtpd_map.svh"

module odtpd_transition (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       cke,
  input  wire logic       odt,
  input  wire logic       refresh_cmd,
  input  wire logic       dll_on_in_pd,
  input  wire logic [4:0] write_latency,
  input  wire logic [9:0] trfc_cycles,
  input  wire logic [5:0] txpdll_cycles,
  output logic            rtt_on,
  output logic            in_window,
  output logic            async_mode
);

  // Pins arrive from outside core_clk's launch point; two stages each
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       cke_q;
  logic       odt_q;
  logic       ref_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // CKE idles high; resetting its stages low would fake a CKE fall after reset
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
    end else begin
      sync1_reg <= {refresh_cmd, odt, cke};
      sync2_reg <= sync1_reg;
    end
  end
  assign cke_q = sync2_reg[0];
  assign odt_q = sync2_reg[1];
  assign ref_q = sync2_reg[2];

  // Latencies derived from write latency
  logic [7:0] odtl;
  logic [7:0] anpd;
  assign odtl = {3'h0, write_latency} - `ODTPD_ODTL_OFS;
  assign anpd = {3'h0, write_latency} - `ODTPD_ANPD_OFS;

  // ODT and CKE history: the sync path taps ODT at the latency depth, and the
  // CKE edge detector compares against the previous sample.
  logic [31:0] odt_hist_reg;
  logic [31:0] odt_hist_next;
  logic [31:0] cke_hist_reg;
  logic [31:0] cke_hist_next;
  always_comb begin
    odt_hist_next = {odt_hist_reg[30:0], odt_q};
    cke_hist_next = {cke_hist_reg[30:0], cke_q};
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      odt_hist_reg <= 32'h0;
      cke_hist_reg <= 32'hffffffff;
    end else begin
      odt_hist_reg <= odt_hist_next;
      cke_hist_reg <= cke_hist_next;
    end
  end

  // Refresh tracking: cycles left of tRFC
  logic [9:0] rfc_left_reg;
  logic [9:0] rfc_left_next;
  always_comb begin
    rfc_left_next = rfc_left_reg;
    if (ref_q && cke_q) begin
      rfc_left_next = trfc_cycles;
    end else if (rfc_left_reg != 10'h0) begin
      rfc_left_next = rfc_left_reg - 10'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rfc_left_reg <= 10'h0;
    end else begin
      rfc_left_reg <= rfc_left_next;
    end
  end

  // Window tracking. Windows are opened on the delayed timeline: a CKE edge
  // seen now means the window began anpd cycles ago, so the tail counters
  // cover only the after-part on plain entry and on exit from ASYNC.
  logic        cke_d;
  logic        cke_fall;
  logic        cke_rise;
  logic [10:0] hold_reg;
  logic [10:0] hold_next;
  logic [10:0] entry_len;
  logic [10:0] exit_len;
  odtpd_pkg::odtpd_mode_t mode_reg;
  odtpd_pkg::odtpd_mode_t mode_next;
  assign cke_d    = cke_hist_reg[0];
  assign cke_fall = cke_d && !cke_q;
  assign cke_rise = !cke_d && cke_q;
  assign entry_len = ({1'b0, rfc_left_reg} > {3'h0, anpd}) ? {1'b0, rfc_left_reg} : {3'h0, anpd};
  assign exit_len  = {3'h0, anpd} + {5'h0, txpdll_cycles};

  always_comb begin
    mode_next = mode_reg;
    hold_next = (hold_reg != 11'h0) ? hold_reg - 11'h1 : 11'h0;
    if (dll_on_in_pd) begin
      mode_next = odtpd_pkg::ODTPD_SYNC;
      hold_next = 11'h0;
    end else begin
      unique case (mode_reg)
        odtpd_pkg::ODTPD_SYNC: begin
          if (cke_fall) begin
            mode_next = odtpd_pkg::ODTPD_ENTRY;
            hold_next = (rfc_left_reg != 10'h0) ? entry_len : 11'h1;
          end
        end
        odtpd_pkg::ODTPD_ENTRY: begin
          if (cke_rise) begin
            // Overlap keeps the window open through the exit end
            mode_next = odtpd_pkg::ODTPD_EXIT;
            hold_next = (hold_reg > exit_len) ? hold_reg : exit_len;
          end else if (hold_reg <= 11'h1) begin
            mode_next = odtpd_pkg::ODTPD_ASYNC;
          end
        end
        odtpd_pkg::ODTPD_ASYNC: begin
          if (cke_rise) begin
            mode_next = odtpd_pkg::ODTPD_EXIT;
            hold_next = {5'h0, txpdll_cycles};
          end
        end
        odtpd_pkg::ODTPD_EXIT: begin
          if (cke_fall) begin
            // Short CKE high: extend to the end of the next entry window
            mode_next = odtpd_pkg::ODTPD_ENTRY;
            hold_next = (rfc_left_reg != 10'h0) ? entry_len : 11'h1;
          end else if (hold_reg <= 11'h1) begin
            mode_next = odtpd_pkg::ODTPD_SYNC;
          end
        end
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_reg <= odtpd_pkg::ODTPD_SYNC;
      hold_reg <= 11'h0;
    end else begin
      mode_reg <= mode_next;
      hold_reg <= hold_next;
    end
  end

  // Termination response. Sync path: ODT delayed by odtl clocks (AL included in
  // write latency). Async path: fixed analog delay, AL ignored. Inside a window
  // the async delay is used, which lies inside both the min and max bounds.
  logic sync_odt;
  logic async_odt;
  logic use_async;
  logic rtt_next;
  assign sync_odt  = odt_hist_reg[odtl[4:0]];
  assign async_odt = odt_hist_reg[`ODTPD_ASYNC_MIN_CYC - 32'd1];
  assign use_async = (mode_reg != odtpd_pkg::ODTPD_SYNC);
  always_comb begin
    rtt_next = use_async ? async_odt : sync_odt;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rtt_on     <= 1'b0;
      in_window  <= 1'b0;
      async_mode <= 1'b0;
    end else begin
      rtt_on     <= rtt_next;
      in_window  <= (mode_next == odtpd_pkg::ODTPD_ENTRY) || (mode_next == odtpd_pkg::ODTPD_EXIT);
      async_mode <= (mode_next == odtpd_pkg::ODTPD_ASYNC);
    end
  end

  property p_dll_on_no_window;
    @(posedge core_clk) disable iff (!reset_n)
      dll_on_in_pd |=> !in_window && !async_mode;
  endproperty
  a_dll_on_no_window: assert property (p_dll_on_no_window) else $error("Window open with DLL on");

  property p_entry_open;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_SYNC) && !dll_on_in_pd && cke_fall |=> in_window;
  endproperty
  a_entry_open: assert property (p_entry_open) else $error("Entry window not opened");

  property p_async_after_entry;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_ENTRY) && (hold_reg <= 11'h1) && !cke_rise && !dll_on_in_pd |=> async_mode;
  endproperty
  a_async_after_entry: assert property (p_async_after_entry) else $error("No async after entry");

  sequence s_exit_start;
    (mode_reg == odtpd_pkg::ODTPD_ASYNC) && cke_rise && !dll_on_in_pd;
  endsequence
  property p_exit_open;
    @(posedge core_clk) disable iff (!reset_n)
      s_exit_start |=> in_window && !async_mode;
  endproperty
  a_exit_open: assert property (p_exit_open) else $error("Exit window not opened");

  property p_async_path;
    @(posedge core_clk) disable iff (!reset_n)
      use_async |=> (rtt_on == $past(odt_q, `ODTPD_ASYNC_MIN_CYC + 1));
  endproperty
  a_async_path: assert property (p_async_path) else $error("Async termination mismatch");

  property p_sync_path;
    @(posedge core_clk) disable iff (!reset_n)
      !use_async |=> (rtt_on == $past(sync_odt));
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("Sync termination mismatch");

  property p_short_low;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_ENTRY) && cke_rise && !dll_on_in_pd |=> in_window;
  endproperty
  a_short_low: assert property (p_short_low) else $error("Overlap lost on short low");

  property p_short_high;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_EXIT) && cke_fall && !dll_on_in_pd |=> in_window && !async_mode;
  endproperty
  a_short_high: assert property (p_short_high) else $error("Overlap lost on short high");

  // Without a refresh pending the entry window closes one clock after CKE low
  sequence s_plain_entry;
    (mode_reg == odtpd_pkg::ODTPD_SYNC) && cke_fall && !dll_on_in_pd && (rfc_left_reg == 10'h0);
  endsequence
  property p_plain_entry_len;
    @(posedge core_clk) disable iff (!reset_n)
      s_plain_entry ##1 (!cke_rise && !dll_on_in_pd) |=> !in_window && async_mode;
  endproperty
  a_plain_entry_len: assert property (p_plain_entry_len) else $error("Plain entry window wrong");

  // A refresh seen with CKE high restarts the tRFC count
  sequence s_refresh_seen;
    ref_q && cke_q;
  endsequence
  property p_refresh_load;
    @(posedge core_clk) disable iff (!reset_n)
      s_refresh_seen |=> (rfc_left_reg == $past(trfc_cycles));
  endproperty
  a_refresh_load: assert property (p_refresh_load) else $error("Refresh count not loaded");

  // Entry during refresh must cover both tANPD and the rest of tRFC
  sequence s_entry_in_refresh;
    (mode_reg == odtpd_pkg::ODTPD_SYNC) && cke_fall && !dll_on_in_pd && (rfc_left_reg != 10'h0);
  endsequence
  property p_entry_refresh_len;
    @(posedge core_clk) disable iff (!reset_n)
      s_entry_in_refresh |=> (hold_reg >= {3'h0, $past(anpd)}) && (hold_reg >= {1'b0, $past(rfc_left_reg)});
  endproperty
  a_entry_refresh_len: assert property (p_entry_refresh_len) else $error("Refresh entry too short");

  property p_exit_len;
    @(posedge core_clk) disable iff (!reset_n)
      s_exit_start |=> (hold_reg == {5'h0, $past(txpdll_cycles)});
  endproperty
  a_exit_len: assert property (p_exit_len) else $error("Exit window length wrong");

  property p_exit_close;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_EXIT) && (hold_reg <= 11'h1) && !cke_fall && !dll_on_in_pd
      |=> !in_window && !async_mode;
  endproperty
  a_exit_close: assert property (p_exit_close) else $error("Exit window did not close");

  // Short CKE low: the exit part alone still spans tXPDLL
  sequence s_short_low;
    (mode_reg == odtpd_pkg::ODTPD_ENTRY) && cke_rise && !dll_on_in_pd;
  endsequence
  property p_short_low_tail;
    @(posedge core_clk) disable iff (!reset_n)
      s_short_low |=> !async_mode && (hold_reg >= {5'h0, $past(txpdll_cycles)});
  endproperty
  a_short_low_tail: assert property (p_short_low_tail) else $error("Short low tail too short");

  // Analog turn-on lands within two clocks of the registered ODT edge
  property p_async_on_bound;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_ASYNC) && !dll_on_in_pd && $rose(odt_q) |-> ##[1:2] rtt_on;
  endproperty
  a_async_on_bound: assert property (p_async_on_bound) else $error("Async turn-on late");

  property p_async_off_bound;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_reg == odtpd_pkg::ODTPD_ASYNC) && !dll_on_in_pd && $fell(odt_q) |-> ##[1:2] !rtt_on;
  endproperty
  a_async_off_bound: assert property (p_async_off_bound) else $error("Async turn-off late");

endmodule : odtpd_transition

// *** sim/odtpd_ctrl_model.sv ***
/* Controller-side model driving CKE, ODT and REFRESH.
   Assumes the bench calls its tasks from one process. */
module odtpd_ctrl_model (
  input  wire logic core_clk,
  output logic      cke,
  output logic      odt,
  output logic      refresh_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke = 1'b1;
    odt = 1'b0;
    refresh_cmd = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // Window bounds come from tANPD, tRFC and tXPDLL; termination is not relied on inside them
  task automatic set_cke(input logic v);
    step(1);
    cke = v;
  endtask : set_cke
  // ODT latency follows WL - 2 on the device side
  task automatic set_odt(input logic v);
    step(1);
    odt = v;
  endtask : set_odt
  task automatic refresh();
    step(1);
    refresh_cmd = 1'b1;
    step(1);
    refresh_cmd = 1'b0;
  endtask : refresh
endmodule : odtpd_ctrl_model

// *** sim/odt_powerdown_mode_transition_tb_top.sv ***
/* Bench for the ODT power-down transition tracker.
   Assumes the controller model drives the pins from a single process. */
module odt_powerdown_mode_transition_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WL = 10;
  localparam int TRFC = 20;
  localparam int TXP = 8;
  logic core_clk, reset_n, dll_on_in_pd, cke, odt, refresh_cmd, rtt_on, in_window, async_mode;
  logic [4:0] wl_cfg;
  logic [9:0] trfc_cfg;
  logic [5:0] txp_cfg;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  odtpd_ctrl_model PM (.core_clk(core_clk), .cke(cke), .odt(odt), .refresh_cmd(refresh_cmd));
  odtpd_transition DUT (.core_clk(core_clk), .reset_n(reset_n), .cke(cke), .odt(odt),
    .refresh_cmd(refresh_cmd), .dll_on_in_pd(dll_on_in_pd), .write_latency(wl_cfg),
    .trfc_cycles(trfc_cfg), .txpdll_cycles(txp_cfg), .rtt_on(rtt_on), .in_window(in_window),
    .async_mode(async_mode));
  // Ceiling well above the few hundred cycles the tests take
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check_bit
  task automatic check_len(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] %0t %s length %0d", $time, what, got);
    end
  endtask : check_len
  task automatic count_win(output int cnt);
    cnt = 0;
    for (int i = 0; i < 10 && in_window !== 1'b1; i++) PM.step(1);
    while (in_window === 1'b1 && cnt < 200) begin
      cnt++;
      PM.step(1);
    end
  endtask : count_win
  task automatic t_sync(input int wl);
    wl_cfg = 5'(wl);
    PM.step(4);
    PM.set_odt(1'b1);
    PM.step(wl - 2);
    check_bit(rtt_on, 1'b0, "sync turn-on too early");
    PM.step(7);
    check_bit(rtt_on, 1'b1, "sync turn-on missing");
    PM.set_odt(1'b0);
    PM.step(wl - 2);
    check_bit(rtt_on, 1'b1, "sync turn-off too early");
    PM.step(7);
    check_bit(rtt_on, 1'b0, "sync turn-off missing");
    PM.step(4);
    $display("sync test wl %0d done", wl);
  endtask : t_sync
  task automatic t_entry_exit();
    PM.set_cke(1'b0);
    count_win(n);
    check_len(n, 1, 2, "entry window");
    PM.step(3);
    check_bit(async_mode, 1'b1, "async after entry");
    PM.set_odt(1'b1);
    PM.step(5);
    check_bit(rtt_on, 1'b1, "async turn-on");
    PM.set_odt(1'b0);
    PM.step(5);
    check_bit(rtt_on, 1'b0, "async turn-off");
    PM.set_cke(1'b1);
    count_win(n);
    check_len(n, TXP, TXP + 1, "exit window");
    PM.step(2);
    check_bit(async_mode, 1'b0, "sync after exit");
    $display("entry exit test done");
  endtask : t_entry_exit
  task automatic t_refresh();
    PM.refresh();
    PM.set_cke(1'b0);
    count_win(n);
    check_len(n, TRFC - 6, TRFC, "refresh entry window");
    PM.set_cke(1'b1);
    count_win(n);
    check_len(n, TXP, TXP + 1, "exit after refresh");
    PM.step(4);
    $display("refresh test done");
  endtask : t_refresh
  task automatic t_short();
    PM.refresh();
    PM.set_cke(1'b0);
    PM.step(2);
    PM.set_cke(1'b1);
    count_win(n);
    check_len(n, WL - 1 + TXP, WL + 3 + TXP, "short low window");
    PM.step(4);
    PM.set_cke(1'b0);
    PM.step(4);
    PM.set_cke(1'b1);
    PM.step(2);
    PM.set_cke(1'b0);
    count_win(n);
    check_len(n, 3, 5, "short high window");
    check_bit(async_mode, 1'b1, "async after short high");
    PM.set_cke(1'b1);
    PM.step(14);
    $display("short pulse test done");
  endtask : t_short
  task automatic t_dll_on();
    dll_on_in_pd = 1'b1;
    PM.set_cke(1'b0);
    count_win(n);
    check_len(n, 0, 0, "window with dll on");
    check_bit(async_mode, 1'b0, "async with dll on");
    PM.set_cke(1'b1);
    PM.step(5);
    dll_on_in_pd = 1'b0;
    $display("dll on test done");
  endtask : t_dll_on
  initial begin
    reset_n = 1'b0;
    dll_on_in_pd = 1'b0;
    wl_cfg = 5'(WL);
    trfc_cfg = 10'(TRFC);
    txp_cfg = 6'(TXP);
    PM.step(10);
    check_bit(in_window, 1'b0, "window in reset");
    check_bit(rtt_on, 1'b0, "termination in reset");
    reset_n = 1'b1;
    PM.step(3);
    t_sync(6);
    t_sync(WL);
    t_entry_exit();
    t_refresh();
    t_short();
    t_dll_on();
    end_of_test();
  end
endmodule : odt_powerdown_mode_transition_tb_top
